// ==== tb/cell_fabric.sv ====
// Neighbouring fabric model: feeds operands into the cells, takes the carry.
// Assumes operands change just after rising hclk.
`timescale 1ns/100ps
module cell_fabric
  import cluster_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Operands from the bench
  input wire logic [NUM_CELLS-1:0] op_a,
  input wire logic [NUM_CELLS-1:0] op_b,
  // Cell operand inputs
  output logic [NUM_CELLS-1:0] data1_in,
  output logic [NUM_CELLS-1:0] data2_in,
  // Carry into the next cluster
  input wire logic cluster_carry_out,
  output logic next_carry_q
);
  assign data1_in = op_a;
  assign data2_in = op_b;
  always_ff @(posedge hclk) begin
    next_carry_q <= cluster_carry_out;
  end
endmodule

// ==== tb/logic_cluster_bench.sv ====
// Self-checking bench for the ten-cell cluster.
// Assumes zero-wait AHB-Lite slave and one-cycle register updates.
`timescale 1ns/100ps
module logic_cluster_bench;
  import cluster_pkg::*;
  typedef struct packed {logic [9:0] a; logic [9:0] b; logic sub; logic cin;} row_t;
  typedef struct packed {logic [9:0] a; logic [9:0] c; logic [10:0] k; logic [9:0] q;} prow_t;
  // Control bits: chip_n,casc,cin,sub,sload,sclr,pl,clr2,clr1,en2,en1
  localparam logic [10:0] K_RUN = 11'h401;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, hready;
  logic [9:0] op_a = 10'h0, op_b = 10'h0, third_data_input = 10'h0, data4_in = 10'h0;
  logic [9:0] data1_in, data2_in, lut_out, cell_reg_q;
  logic [10:0] k = 11'h400;
  logic cluster_carry_out, next_carry_q;
  int bad_count = 0;
  int compares = 0;
  row_t rows [5] = '{'{10'h3FF, 10'h001, 1'b0, 1'b1}, '{10'h1F0, 10'h010, 1'b0, 1'b0},
    '{10'h200, 10'h001, 1'b1, 1'b0}, '{10'h000, 10'h000, 1'b1, 1'b1},
    '{10'h155, 10'h2AA, 1'b0, 1'b0}};
  prow_t prows [8] = '{'{10'h155, 10'h3FF, 11'h411, 10'h3FF},
    '{10'h155, 10'h3FF, 11'h415, 10'h000}, '{10'h155, 10'h000, 11'h409, 10'h155},
    '{10'h0AA, 10'h000, 11'h402, 10'h155}, '{10'h0AA, 10'h2A5, 11'h441, 10'h2A5},
    '{10'h0AA, 10'h3FF, 11'h011, 10'h000}, '{10'h0AA, 10'h2A5, 11'h441, 10'h2A5},
    '{10'h0AA, 10'h000, 11'h421, 10'h000}};
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  logic_cluster dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .data1_in(data1_in),
    .data2_in(data2_in), .third_data_input(third_data_input), .data4_in(data4_in),
    .cluster_clock_enable_one(k[0]), .cluster_clock_enable_two(k[1]),
    .async_clear_one(k[2]), .async_clear_two(k[3]), .preset_load(k[4]),
    .sync_clear(k[5]), .sync_load(k[6]), .add_sub(k[7]), .cluster_carry_in(k[8]),
    .reg_cascade_in(k[9]), .chip_wide_clear_n(k[10]), .lut_out(lut_out),
    .cell_reg_q(cell_reg_q), .cluster_carry_out(cluster_carry_out));
  cell_fabric fabric (.hclk(hclk), .op_a(op_a), .op_b(op_b), .data1_in(data1_in),
    .data2_in(data2_in), .cluster_carry_out(cluster_carry_out), .next_carry_q(next_carry_q));
  task automatic report_and_stop(input int extra);
    bad_count += extra;
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Master never assumes latency; bound only cuts a hang
  task automatic wait_rdy();
    int n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) report_and_stop(1);
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    haddr <= addr;
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic fab(input logic [9:0] a, b, c, input logic [10:0] kk);
    @(posedge hclk);
    op_a <= a;
    op_b <= b;
    third_data_input <= c;
    k <= kk;
    @(negedge hclk);
  endtask
  initial begin
    logic [9:0] bb;
    logic [10:0] s;
    logic [31:0] rd;
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    chk({cell_reg_q, lut_out, hreadyout, hresp}, 32'h2);
    @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++) bus(1'b1, 4 * i, i == 0 ? 32'h0005_0000 : 32'h0001_0000, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h0005_0000);
    bus(1'b0, 32'h80, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bb = rows[i].b ^ {10{rows[i].sub}};
      s = {1'b0, rows[i].a} + {1'b0, bb} + {10'h0, rows[i].sub};
      fab(rows[i].a, rows[i].b, 10'h0, K_RUN | {2'h0, rows[i].cin, rows[i].sub, 7'h0});
      chk({cluster_carry_out, lut_out}, s);
      @(negedge hclk);
      chk({cell_reg_q, lut_out}, {s[9:0], s[9:0]});
      chk(next_carry_q, s[10]);
    end
    bus(1'b1, 32'h0C, 32'h0005_0000, rd);
    fab(10'h3FF, 10'h001, 10'h0, K_RUN);
    chk({cluster_carry_out, lut_out}, 32'h3F8);
    bus(1'b1, 32'h40, 32'h1, rd);
    for (int i = 0; i < 8; i++) begin
      fab(prows[i].a, 10'h0, prows[i].c, prows[i].k);
      @(negedge hclk);
      chk(cell_reg_q, prows[i].q);
    end
    for (int i = 0; i < 10; i++) bus(1'b1, 4 * i, i == 1 ? 32'h00C0_AAAA : 32'h0040_AAAA, rd);
    fab(10'h001, 10'h0, 10'h0, K_RUN | 11'h200);
    chk(lut_out, 32'h003);
    fab(10'h001, 10'h0, 10'h0, K_RUN);
    fab(10'h001, 10'h0, 10'h0, 11'h400);
    @(negedge hclk);
    chk({cell_reg_q, lut_out}, {10'h002, 10'h003});
    bus(1'b0, 32'h44, 32'h0, rd);
    chk(rd & 32'h3FF, 32'h002);
    report_and_stop(0);
  end
endmodule

// ==== verilog/cluster_pkg.sv ====
// Constants for one ten-cell logic cluster with an AHB-Lite configuration port.
// Assumes one clock, hclk, with fabric inputs synchronous to it.
// Behaviour
// - Cluster add/subtract select makes each cell form A plus B or A minus B.
// - Subtract inverts every B bit and forces the chain carry-in to one.
// - Each cell is normal or arithmetic, with four inputs routed per mode.
// - Cluster clock, enable, clears, preset/load, sync clear/load serve both modes.
// - Normal mode: four-input lookup; third input is data or incoming carry.
// - Normal mode lookup result cascades straight into the next cell.
// - Asynchronous load takes its value from the third data input; here it is taken on the hclk edge.
// - Arithmetic mode: sums and carries for carry zero and one, rail chosen.
// - Each rail's carry input selects that rail's carry-out for the next bit.
// - Arithmetic cells offer enable, count, up/down, sync clear/load, add/sub.
// - Counter enable and direction come from the cell's own data inputs.
// - A carry chain may start at any cell of the cluster.
// - Cluster carry regenerates after cells five and ten; clusters chain onward.
// - Final carry-out is delivered to fabric routing.
// - Arithmetic sum is available both combinational and registered at once.
// - Preset is an asynchronous load of a one, no inversion; here it is taken on the hclk edge.
// - Clear wins when clear and preset/load coincide.
// - Two clear lines and one preset line per cluster.
// - Enabled chip-wide active-low clear resets all registers, overriding all.
// - Add/subtract drives carry only of a chain's first cell.
// - Registers chain into a shift register while lookups do other work.
// - A cluster holds ten cells sharing controls and carry chain.
// - Each clock enable gates its paired clock for every register using it; here both enables gate the single hclk.
package cluster_pkg;
  localparam int NUM_CELLS = 10;
  localparam int SPLIT_CELL = 5;
  localparam logic [7:0] CELL_CFG_BASE = 8'h00;
  localparam logic [7:0] GLOBAL_CTRL_OFF = 8'h40;
  localparam logic [7:0] STATUS_OFF = 8'h44;
  localparam int LUT_MASK_LSB = 0;
  localparam int MODE_ARITH_BIT = 16;
  localparam int LUT_CARRY_BIT = 17;
  localparam int CHAIN_START_BIT = 18;
  localparam int CLK_SEL_BIT = 19;
  localparam int CLR_SEL_BIT = 20;
  localparam int COUNTER_BIT = 21;
  localparam int REG_CASCADE_BIT = 22;
  localparam int LUT_CASCADE_BIT = 23;
  localparam int CHIP_CLR_EN_BIT = 0;
  localparam int STATUS_CARRY_BIT = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic GLOBAL_RESET = 1'b0;
endpackage

// ==== verilog/logic_cluster.sv ====
// Ten-cell logic cluster: lookup, dual-rail carry select, cell registers.
// Assumes a single AHB-Lite master; fabric inputs synchronous to hclk.
`timescale 1ns/100ps
module logic_cluster
  import cluster_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Cell data inputs
  input wire logic [NUM_CELLS-1:0] data1_in,
  input wire logic [NUM_CELLS-1:0] data2_in,
  input wire logic [NUM_CELLS-1:0] third_data_input,
  input wire logic [NUM_CELLS-1:0] data4_in,
  // Cluster-wide controls
  input wire logic cluster_clock_enable_one,
  input wire logic cluster_clock_enable_two,
  input wire logic async_clear_one,
  input wire logic async_clear_two,
  input wire logic preset_load,
  input wire logic sync_clear,
  input wire logic sync_load,
  input wire logic add_sub,
  input wire logic cluster_carry_in,
  input wire logic reg_cascade_in,
  input wire logic chip_wide_clear_n,
  // Cell outputs
  output logic [NUM_CELLS-1:0] lut_out,
  output logic [NUM_CELLS-1:0] cell_reg_q,
  output logic cluster_carry_out
);

  logic [31:0] cfg_q [NUM_CELLS];
  logic chip_clr_en_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [NUM_CELLS-1:0] rail0_in, rail1_in, rail0_out, rail1_out;
  logic [NUM_CELLS-1:0] sum, carry_eff;
  logic regen_carry;
  logic [NUM_CELLS-1:0] en_act, clr_act;
  logic chip_clr;
  logic [NUM_CELLS-1:0] plain_arith;

  // True when the offset hits the configuration word of cell i
  function automatic logic cell_hit(input logic [7:0] a, input int i);
    return a == CELL_CFG_BASE + 8'(4 * i);
  endfunction

  // Address phase accepted
  wire addr_ok = hsel && htrans[1] && hready;

  // Write lands in the data phase, when hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  generate
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cfg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_q[i] <= CFG_RESET;
        end else if (wr_pend_q && cell_hit(wr_addr_q, i)) begin
          cfg_q[i] <= hwdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_clr_en_q <= GLOBAL_RESET;
    end else if (wr_pend_q && wr_addr_q == GLOBAL_CTRL_OFF) begin
      chip_clr_en_q <= hwdata[CHIP_CLR_EN_BIT];
    end
  end

  // Read data registered from the address phase, so zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      for (int i = 0; i < NUM_CELLS; i++) begin
        if (cell_hit(haddr[7:0], i)) begin
          hrdata <= cfg_q[i];
        end
      end
      if (haddr[7:0] == GLOBAL_CTRL_OFF) begin
        hrdata <= {31'h0, chip_clr_en_q};
      end
      if (haddr[7:0] == STATUS_OFF) begin
        hrdata <= {15'h0, cluster_carry_out, 6'h00, cell_reg_q};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Carry-select chain and lookup functions
  always_comb begin
    logic a, b, p, sel, in3, in1, start_c;
    logic [3:0] idx;
    // Loop temporaries start defined so no latch is inferred
    a = 1'b0;
    b = 1'b0;
    p = 1'b0;
    sel = 1'b0;
    in3 = 1'b0;
    in1 = 1'b0;
    start_c = 1'b0;
    idx = 4'h0;
    rail0_in = '0;
    rail1_in = '0;
    rail0_out = '0;
    rail1_out = '0;
    sum = '0;
    carry_eff = '0;
    lut_out = '0;
    regen_carry = cluster_carry_in;
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (i == 0 || i == SPLIT_CELL) begin
        rail0_in[i] = 1'b0;
        rail1_in[i] = 1'b1;
      end else begin
        rail0_in[i] = rail0_out[i-1];
        rail1_in[i] = rail1_out[i-1];
      end
      start_c = cfg_q[i][COUNTER_BIT] ? data4_in[i] : add_sub;
      if (cfg_q[i][CHAIN_START_BIT]) begin
        rail0_in[i] = start_c;
        rail1_in[i] = start_c;
      end
      if (cfg_q[i][COUNTER_BIT]) begin
        a = cell_reg_q[i];
        b = ~data4_in[i];
      end else begin
        a = data1_in[i];
        b = data2_in[i] ^ add_sub;
      end
      p = a ^ b;
      rail0_out[i] = rail0_in[i] ? (a | b) : (a & b);
      rail1_out[i] = rail1_in[i] ? (a | b) : (a & b);
      sel = (i < SPLIT_CELL) ? cluster_carry_in : regen_carry;
      carry_eff[i] = sel ? rail1_in[i] : rail0_in[i];
      sum[i] = p ^ carry_eff[i];
      if (i == SPLIT_CELL - 1) begin
        regen_carry = cluster_carry_in ? rail1_out[i] : rail0_out[i];
      end
      // third lookup input: data or carry
      in3 = cfg_q[i][LUT_CARRY_BIT] ? carry_eff[i] : third_data_input[i];
      in1 = (i > 0 && cfg_q[i][LUT_CASCADE_BIT]) ? lut_out[(i > 0) ? i-1 : 0]
                                                 : data1_in[i];
      idx = {data4_in[i], in3, data2_in[i], in1};
      lut_out[i] = cfg_q[i][MODE_ARITH_BIT] ? sum[i] : cfg_q[i][LUT_MASK_LSB + idx];
    end
    cluster_carry_out = regen_carry ? rail1_out[NUM_CELLS-1] : rail0_out[NUM_CELLS-1];
  end

  assign chip_clr = chip_clr_en_q && !chip_wide_clear_n;

  // Async controls are sampled on hclk; no fabric value enters an async path
  // ten cells share controls
  generate
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
      // Plain adder cell: arithmetic, no counter, chain starts only at cell 0
      assign plain_arith[i] = cfg_q[i][MODE_ARITH_BIT] && !cfg_q[i][COUNTER_BIT] &&
                              (cfg_q[i][CHAIN_START_BIT] == (i == 0));
      // two clear lines, one preset line
      assign clr_act[i] = cfg_q[i][CLR_SEL_BIT] ? async_clear_two : async_clear_one;
      assign en_act[i] = cfg_q[i][CLK_SEL_BIT] ? cluster_clock_enable_two
                                               : cluster_clock_enable_one;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cell_reg_q[i] <= 1'b0;
        end else if (chip_clr) begin
          cell_reg_q[i] <= 1'b0;
        end else if (clr_act[i]) begin
          cell_reg_q[i] <= 1'b0;
        // load third input, preset when high
        end else if (preset_load) begin
          cell_reg_q[i] <= third_data_input[i];
        end else if (en_act[i]) begin
          // sync clear and load cluster wide
          if (sync_clear) begin
            cell_reg_q[i] <= 1'b0;
          end else if (sync_load) begin
            cell_reg_q[i] <= third_data_input[i];
          end else if (cfg_q[i][REG_CASCADE_BIT]) begin
            cell_reg_q[i] <= (i == 0) ? reg_cascade_in : cell_reg_q[(i > 0) ? i-1 : 0];
          end else if (!cfg_q[i][COUNTER_BIT] || third_data_input[i]) begin
            cell_reg_q[i] <= lut_out[i];
          end
        end
      end
    end
  endgenerate

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire quiet0 = !chip_clr && !clr_act[0] && !preset_load;
  wire arith0 = cfg_q[0][MODE_ARITH_BIT] && cfg_q[0][CHAIN_START_BIT] &&
                !cfg_q[0][COUNTER_BIT];
  // Reference sum for a whole-cluster adder, independent of the rail logic
  wire [10:0] full_sum = {1'b0, data1_in} + {1'b0, data2_in};
  wire run0 = quiet0 && en_act[0] && !sync_clear && !sync_load &&
              !cfg_q[0][REG_CASCADE_BIT];
  wire count0 = cfg_q[0][MODE_ARITH_BIT] && cfg_q[0][COUNTER_BIT] &&
                cfg_q[0][CHAIN_START_BIT];

  chip_clear_a: assert property (chip_clr |=> cell_reg_q == '0)
    else $error("chip-wide clear did not zero registers");
  clear_wins_a: assert property (!chip_clr && clr_act[0] && preset_load
                                 |=> !cell_reg_q[0])
    else $error("clear lost against preset/load");
  async_load_a: assert property (!chip_clr && !clr_act[0] && preset_load
                                 |=> cell_reg_q[0] == $past(third_data_input[0]))
    else $error("load value not from third input");
  enable_hold_a: assert property (quiet0 && !en_act[0]
                                  |=> $stable(cell_reg_q[0]))
    else $error("register moved with enable low");
  sync_clear_a: assert property (quiet0 && en_act[0] && sync_clear
                                 |=> !cell_reg_q[0])
    else $error("sync clear ignored");
  sub_zero_a: assert property (arith0 && add_sub && data1_in[0] == data2_in[0]
                               |-> !lut_out[0])
    else $error("a minus a not zero");
  add_lsb_a: assert property (arith0 && !add_sub
                              |-> lut_out[0] == (data1_in[0] ^ data2_in[0]))
    else $error("lsb sum wrong");
  shift_chain_a: assert property (!chip_clr && !clr_act[1] && !preset_load && en_act[1] &&
                                  !sync_clear && !sync_load && cfg_q[1][REG_CASCADE_BIT]
                                  |=> cell_reg_q[1] == $past(cell_reg_q[0]))
    else $error("register cascade broken");
  acc_reg_a: assert property (quiet0 && en_act[0] && !sync_clear && !sync_load &&
                              !cfg_q[0][REG_CASCADE_BIT] && !cfg_q[0][COUNTER_BIT]
                              |=> cell_reg_q[0] == $past(lut_out[0]))
    else $error("registered sum differs");
  add_full_a: assert property (&plain_arith && !add_sub
                               |-> {cluster_carry_out, lut_out} == full_sum)
    else $error("ten-bit sum or final carry wrong");
  sub_full_a: assert property (&plain_arith && add_sub
                               |-> lut_out == (data1_in - data2_in))
    else $error("ten-bit difference wrong");
  rail_pick_a: assert property (!add_sub && arith0 && cfg_q[1][MODE_ARITH_BIT] &&
                                !cfg_q[1][CHAIN_START_BIT] && !cfg_q[1][COUNTER_BIT]
                                |-> lut_out[1] == (data1_in[1] ^ data2_in[1] ^
                                                   (data1_in[0] & data2_in[0])))
    else $error("second bit carry wrong");
  mid_start_a: assert property (cfg_q[5][MODE_ARITH_BIT] && cfg_q[5][CHAIN_START_BIT] &&
                                !cfg_q[5][COUNTER_BIT]
                                |-> lut_out[5] == (data1_in[5] ^ data2_in[5]))
    else $error("chain start inside cluster wrong");
  lut_chain_a: assert property (!cfg_q[1][MODE_ARITH_BIT] && cfg_q[1][LUT_CASCADE_BIT] &&
                                cfg_q[1][15:0] == 16'hAAAA
                                |-> lut_out[1] == lut_out[0])
    else $error("lookup cascade broken");
  lut_third_data_input_a: assert property (!cfg_q[0][MODE_ARITH_BIT] && !cfg_q[0][LUT_CARRY_BIT] &&
                                cfg_q[0][15:0] == 16'hF0F0
                                |-> lut_out[0] == third_data_input[0])
    else $error("third lookup input not data");
  preset_one_a: assert property (!chip_clr && !clr_act[0] && preset_load &&
                                 third_data_input[0] |=> cell_reg_q[0])
    else $error("preset did not load one");
  clear_two_a: assert property (!chip_clr && cfg_q[2][CLR_SEL_BIT] && async_clear_two
                                |=> !cell_reg_q[2])
    else $error("second clear line ignored");
  clear_one_a: assert property (!chip_clr && !cfg_q[2][CLR_SEL_BIT] && async_clear_one
                                |=> !cell_reg_q[2])
    else $error("first clear line ignored");
  sync_load_a: assert property (quiet0 && en_act[0] && !sync_clear && sync_load
                                |=> cell_reg_q[0] == $past(third_data_input[0]))
    else $error("sync load value wrong");
  enable_two_a: assert property (quiet0 && cfg_q[0][CLK_SEL_BIT] &&
                                 !cluster_clock_enable_two
                                 |=> $stable(cell_reg_q[0]))
    else $error("register moved with second enable low");
  cascade_in_a: assert property (quiet0 && en_act[0] && !sync_clear && !sync_load &&
                                 cfg_q[0][REG_CASCADE_BIT]
                                 |=> cell_reg_q[0] == $past(reg_cascade_in))
    else $error("cascade input not shifted in");
  count_step_a: assert property (run0 && count0 && third_data_input[0]
                                 |=> cell_reg_q[0] != $past(cell_reg_q[0]))
    else $error("counter lsb did not step");
  count_hold_a: assert property (run0 && count0 && !third_data_input[0]
                                 |=> $stable(cell_reg_q[0]))
    else $error("counter moved with count enable low");

  sub_cov: cover property (arith0 && add_sub);
  shift_cov: cover property (cfg_q[1][REG_CASCADE_BIT] && en_act[1]);
  carry_cov: cover property (cluster_carry_out);
  clear_cov: cover property (chip_clr);
  count_cov: cover property (count0 && en_act[0]);

endmodule
